/* File: rtl/port_bit_cell.sv */
`timescale 1ns/100ps
// one port: latch, direction, pin drive and read-back mux
module port_bit_cell #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         wr_data_i,
    input  wire logic         wr_dir_i,
    input  wire logic [W-1:0] wdata_i,
    input  wire logic [W-1:0] pin_i,
    input  wire logic [W-1:0] alt_sel_i,
    input  wire logic [W-1:0] alt_out_i,
    input  wire logic [W-1:0] alt_oe_i,
    input  wire logic [W-1:0] od_i,
    output logic      [W-1:0] pin_o,
    output logic      [W-1:0] pin_oe_o,
    output logic      [W-1:0] rdata_o,
    output logic      [W-1:0] dir_o
);
    logic [W-1:0] latch_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] drv_val;
    logic [W-1:0] drv_en;

    // latch written regardless of direction
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            latch_q <= W'(port_pkg::LATCH_RST);
        end else if (wr_data_i) begin
            latch_q <= wdata_i;
        end
    end

    // one direction bit per pin, cleared at reset
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dir_q <= W'(port_pkg::DIR_RST);
        end else if (wr_dir_i) begin
            dir_q <= wdata_i;
        end
    end

    // alternate function takes the pin, latch untouched
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (alt_sel_i[i]) begin
                drv_val[i] = alt_out_i[i];
                drv_en[i]  = alt_oe_i[i] & (~od_i[i] | ~alt_out_i[i]);
            end else begin
                drv_val[i] = latch_q[i];
                drv_en[i]  = dir_q[i] & (~od_i[i] | ~latch_q[i]);
            end
        end
    end

    // registered pin drive and read-back
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pin_o    <= '0;
            pin_oe_o <= '0;
            rdata_o  <= '0;
        end else begin
            pin_o    <= drv_val;
            pin_oe_o <= drv_en;
            rdata_o  <= (dir_q & latch_q) | (~dir_q & pin_i);
        end
    end

    assign dir_o = dir_q;
endmodule

/* File: rtl/port_pins_with_shared_functions.sv */
`timescale 1ns/100ps
module port_pins_with_shared_functions (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // port pins
    input  wire logic [7:0]  port_zero_i,
    output logic      [7:0]  port_zero_o,
    output logic      [7:0]  port_zero_oe_o,
    input  wire logic [6:0]  port_one_i,
    output logic      [6:0]  port_one_o,
    output logic      [6:0]  port_one_oe_o,
    input  wire logic [7:0]  port_two_i,
    output logic      [7:0]  port_two_o,
    output logic      [7:0]  port_two_oe_o,
    input  wire logic [1:0]  port_three_i,
    output logic      [1:0]  port_three_o,
    output logic      [1:0]  port_three_oe_o,
    input  wire logic [1:0]  port_five_i,
    output logic      [3:0]  port_five_o,
    // peripheral side
    input  wire logic [4:0]  pulse_out_i,
    input  wire logic        scl1_out_i,
    input  wire logic        scl2_out_i,
    input  wire logic        sda1_out_i,
    input  wire logic        sda2_out_i,
    input  wire logic        sda3_out_i,
    input  wire logic        scl3_out_i,
    input  wire logic        shift_clk_out_i,
    input  wire logic        shift_clk_oe_i,
    input  wire logic        shift_data_out_i,
    input  wire logic        clock_control_out_i,
    input  wire logic [3:0]  display_out_i,
    output logic      [3:0]  serbus_in_o,
    output logic      [1:0]  serbus3_in_o,
    output logic             shift_clk_in_o,
    output logic             shift_data_in_o,
    output logic             ext_irq_in_1_o,
    output logic             ext_irq_in_2_o,
    output logic             ext_irq_in_3_o,
    output logic             timer_b_ext_clock_o,
    output logic             timer_b_alt_clock_o,
    output logic             timer_c_ext_clock_o,
    output logic      [8:1]  analog_in_o,
    output logic             hsync_in_o,
    output logic             vsync_in_o
);
    //////////////////////////////////////////////////////////////////////////
    logic [8:0] func_sel_q;
    logic [3:0] five_latch_q;
    logic       acc;
    logic       wr;
    logic [3:0] wr_data_sel;
    logic [3:0] wr_dir_sel;
    logic [7:0] rd0;
    logic [6:0] rd1;
    logic [7:0] rd2;
    logic [1:0] rd3;
    logic [7:0] dir0;
    logic [6:0] dir1;
    logic [7:0] dir2;
    logic [1:0] dir3;
    logic       map_hit;
    logic [31:0] rd_mux;

    // access phase decode; slave answers in the first access cycle
    assign acc = psel & penable;
    assign wr  = acc & pwrite;

    always_comb begin
        wr_data_sel[0] = wr & (paddr == port_pkg::OFS_PORT_ZERO_DATA);
        wr_dir_sel[0]  = wr & (paddr == port_pkg::OFS_PORT_ZERO_DIR);
        wr_data_sel[1] = wr & (paddr == port_pkg::OFS_PORT_ONE_DATA);
        wr_dir_sel[1]  = wr & (paddr == port_pkg::OFS_PORT_ONE_DIR);
        wr_data_sel[2] = wr & (paddr == port_pkg::OFS_PORT_TWO_DATA);
        wr_dir_sel[2]  = wr & (paddr == port_pkg::OFS_PORT_TWO_DIR);
        wr_data_sel[3] = wr & (paddr == port_pkg::OFS_PORT_THREE_DATA);
        wr_dir_sel[3]  = wr & (paddr == port_pkg::OFS_PORT_THREE_DIR);
    end

    //////////////////////////////////////////////////////////////////////////
    // function select and port five output latch
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            func_sel_q   <= port_pkg::FS_RST;
            five_latch_q <= 4'h0;
        end else begin
            if (wr && paddr == port_pkg::OFS_FUNC_SEL) begin
                func_sel_q <= pwdata[8:0];
            end
            if (wr && paddr == port_pkg::OFS_PORT_FIVE_DATA) begin
                five_latch_q <= pwdata[5:2];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // port zero: open drain, pulse outputs on bits 0..4
    port_bit_cell #(.W(port_pkg::PORT_ZERO_W)) u_port_zero (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_data_i (wr_data_sel[0]),
        .wr_dir_i  (wr_dir_sel[0]),
        .wdata_i   (pwdata[7:0]),
        .pin_i     (port_zero_i),
        .alt_sel_i ({3'h0, func_sel_q[4:0]}),
        .alt_out_i ({3'h0, pulse_out_i}),
        .alt_oe_i  (8'hff),
        .od_i      (8'hff),
        .pin_o     (port_zero_o),
        .pin_oe_o  (port_zero_oe_o),
        .rdata_o   (rd0),
        .dir_o     (dir0)
    );

    // port one: cmos, serial bus open drain on 1..4, clock control on 0
    port_bit_cell #(.W(port_pkg::PORT_ONE_W)) u_port_one (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_data_i (wr_data_sel[1]),
        .wr_dir_i  (wr_dir_sel[1]),
        .wdata_i   (pwdata[6:0]),
        .pin_i     (port_one_i),
        .alt_sel_i ({2'h0, {4{func_sel_q[port_pkg::FS_SERBUS]}},
                     func_sel_q[port_pkg::FS_CLKCTL]}),
        .alt_out_i ({2'h0, sda2_out_i, sda1_out_i, scl2_out_i, scl1_out_i,
                     clock_control_out_i}),
        .alt_oe_i  (7'h7f),
        .od_i      ({2'h0, {4{func_sel_q[port_pkg::FS_SERBUS]}}, 1'b0}),
        .pin_o     (port_one_o),
        .pin_oe_o  (port_one_oe_o),
        .rdata_o   (rd1),
        .dir_o     (dir1)
    );

    // port two: shift clock open drain, data out open drain
    port_bit_cell #(.W(port_pkg::PORT_TWO_W)) u_port_two (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_data_i (wr_data_sel[2]),
        .wr_dir_i  (wr_dir_sel[2]),
        .wdata_i   (pwdata[7:0]),
        .pin_i     (port_two_i),
        .alt_sel_i ({6'h0, {2{func_sel_q[port_pkg::FS_SHIFT]}}}),
        .alt_out_i ({6'h0, shift_data_out_i, shift_clk_out_i}),
        .alt_oe_i  ({6'h0, 1'b1, shift_clk_oe_i}),
        .od_i      ({6'h0, {2{func_sel_q[port_pkg::FS_SHIFT]}}}),
        .pin_o     (port_two_o),
        .pin_oe_o  (port_two_oe_o),
        .rdata_o   (rd2),
        .dir_o     (dir2)
    );

    // port three: serial bus channel three, open drain
    port_bit_cell #(.W(port_pkg::PORT_THREE_W)) u_port_three (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_data_i (wr_data_sel[3]),
        .wr_dir_i  (wr_dir_sel[3]),
        .wdata_i   (pwdata[1:0]),
        .pin_i     (port_three_i),
        .alt_sel_i ({2{func_sel_q[port_pkg::FS_SERBUS]}}),
        .alt_out_i ({scl3_out_i, sda3_out_i}),
        .alt_oe_i  (2'h3),
        .od_i      ({2{func_sel_q[port_pkg::FS_SERBUS]}}),
        .pin_o     (port_three_o),
        .pin_oe_o  (port_three_oe_o),
        .rdata_o   (rd3),
        .dir_o     (dir3)
    );

    //////////////////////////////////////////////////////////////////////////
    // inputs routed to peripherals, registered
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            serbus_in_o         <= 4'h0;
            serbus3_in_o        <= 2'h0;
            shift_clk_in_o      <= 1'b0;
            shift_data_in_o     <= 1'b0;
            ext_irq_in_1_o      <= 1'b0;
            ext_irq_in_2_o      <= 1'b0;
            ext_irq_in_3_o      <= 1'b0;
            timer_b_ext_clock_o <= 1'b0;
            timer_b_alt_clock_o <= 1'b0;
            timer_c_ext_clock_o <= 1'b0;
            analog_in_o         <= 8'h00;
            hsync_in_o          <= 1'b0;
            vsync_in_o          <= 1'b0;
        end else begin
            serbus_in_o         <= port_one_i[4:1];
            serbus3_in_o        <= port_three_i;
            shift_clk_in_o      <= port_two_i[0];
            shift_data_in_o     <= port_two_i[2];
            ext_irq_in_2_o      <= port_zero_i[6];
            ext_irq_in_1_o      <= port_zero_i[7];
            ext_irq_in_3_o      <= port_two_i[5];
            timer_c_ext_clock_o <= port_two_i[3];
            timer_b_ext_clock_o <= port_two_i[4];
            timer_b_alt_clock_o <= port_one_i[6];
            analog_in_o         <= {port_one_i[6], port_two_i[2:0],
                                    port_zero_i[6:3]};
            hsync_in_o          <= port_five_i[0];
            vsync_in_o          <= port_five_i[1];
        end
    end

    // port five outputs: latch or display engine
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            port_five_o <= 4'h0;
        end else if (func_sel_q[port_pkg::FS_DISPLAY]) begin
            port_five_o <= display_out_i;
        end else begin
            port_five_o <= five_latch_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        map_hit = 1'b1;
        rd_mux  = 32'h0;
        unique case (paddr)
            port_pkg::OFS_PORT_ZERO_DATA:  rd_mux = {24'h0, rd0};
            port_pkg::OFS_PORT_ZERO_DIR:   rd_mux = {24'h0, dir0};
            port_pkg::OFS_PORT_ONE_DATA:   rd_mux = {25'h0, rd1};
            port_pkg::OFS_PORT_ONE_DIR:    rd_mux = {25'h0, dir1};
            port_pkg::OFS_PORT_TWO_DATA:   rd_mux = {24'h0, rd2};
            port_pkg::OFS_PORT_TWO_DIR:    rd_mux = {24'h0, dir2};
            port_pkg::OFS_PORT_THREE_DATA: rd_mux = {30'h0, rd3};
            port_pkg::OFS_PORT_THREE_DIR:  rd_mux = {30'h0, dir3};
            port_pkg::OFS_PORT_FIVE_DATA:  rd_mux = {26'h0, five_latch_q, port_five_i};
            port_pkg::OFS_FUNC_SEL:        rd_mux = {23'h0, func_sel_q};
            default:                       map_hit = 1'b0;
        endcase
    end

    // apb answer: registered, no wait state, error on unmapped address
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~map_hit;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
        end
    end
endmodule

/* File: rtl/port_pkg.sv */
package port_pkg;
    // port widths
    localparam int PORT_ZERO_W  = 8;
    localparam int PORT_ONE_W   = 7;
    localparam int PORT_TWO_W   = 8;
    localparam int PORT_THREE_W = 2;
    localparam int PORT_FIVE_IN_W  = 2;
    localparam int PORT_FIVE_OUT_W = 4;

    // register byte offsets
    localparam logic [11:0] OFS_PORT_ZERO_DATA  = 12'h000;
    localparam logic [11:0] OFS_PORT_ZERO_DIR   = 12'h004;
    localparam logic [11:0] OFS_PORT_ONE_DATA   = 12'h008;
    localparam logic [11:0] OFS_PORT_ONE_DIR    = 12'h00c;
    localparam logic [11:0] OFS_PORT_TWO_DATA   = 12'h010;
    localparam logic [11:0] OFS_PORT_TWO_DIR    = 12'h014;
    localparam logic [11:0] OFS_PORT_THREE_DATA = 12'h018;
    localparam logic [11:0] OFS_PORT_THREE_DIR  = 12'h01c;
    localparam logic [11:0] OFS_PORT_FIVE_DATA  = 12'h020;
    localparam logic [11:0] OFS_FUNC_SEL        = 12'h024;

    // alternate function select bits
    localparam int FS_PULSE    = 0; // 5 bits: pulse_out_0..4
    localparam int FS_SERBUS   = 5; // two-wire serial on port one/three
    localparam int FS_SHIFT    = 6; // clocked serial port on port two
    localparam int FS_CLKCTL   = 7; // clock_control_out on port one bit 0
    localparam int FS_DISPLAY  = 8; // display outputs on port five
    localparam int FS_W        = 9;

    // reset values
    localparam logic [7:0]  DIR_RST   = 8'h00;
    localparam logic [7:0]  LATCH_RST = 8'h00;
    localparam logic [8:0]  FS_RST    = 9'h000;

    // reset hold time of the external source
    localparam int RST_HOLD_US = 2000;
endpackage

/* File: tb/pin_board.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// board side of the pins: the board sets the level wherever the chip lets go
module pin_board #(
    parameter int W = 25
) (
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] drv_oe_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] level_o
);
    // chip drive wins where enabled, else the board level (pull-up or source)
    assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_i);
endmodule

/* File: tb/port_pins_asserts.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// protocol and pin checks on the top-level ports
module port_pins_chk (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic [7:0]  port_zero_i,
    input wire logic [7:0]  port_zero_o,
    input wire logic [7:0]  port_zero_oe_o,
    input wire logic [6:0]  port_one_i,
    input wire logic [6:0]  port_one_oe_o,
    input wire logic [7:0]  port_two_i,
    input wire logic [1:0]  port_three_oe_o,
    input wire logic [1:0]  port_five_i,
    input wire logic        ext_irq_in_1_o,
    input wire logic        ext_irq_in_2_o,
    input wire logic        ext_irq_in_3_o,
    input wire logic        timer_b_ext_clock_o,
    input wire logic        timer_c_ext_clock_o,
    input wire logic [8:1]  analog_in_o,
    input wire logic        hsync_in_o,
    input wire logic        vsync_in_o,
    input wire logic [1:0]  port_three_i,
    input wire logic [3:0]  serbus_in_o,
    input wire logic [1:0]  serbus3_in_o,
    input wire logic        shift_clk_in_o,
    input wire logic        shift_data_in_o,
    input wire logic        timer_b_alt_clock_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////
    // pin drive after reset and bus handshake
    AST_RST_INPUTS: assert property ($rose(rst_n_i) |->
        {port_zero_oe_o, port_one_oe_o, port_three_oe_o} == 17'h0)
        else $error("pin drive active right after reset");
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer in the first access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_SLVERR_READY: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    AST_RDATA_UPPER: assert property (pready |-> prdata[31:9] == 23'h0)
        else $error("upper read data bits not zero");
    // pin structure and input routing
    AST_P0_OPEN_DRAIN: assert property ((port_zero_oe_o & port_zero_o) == 8'h00)
        else $error("port zero drives a high level");
    AST_IRQ_ROUTE: assert property ($past(rst_n_i) |->
        {ext_irq_in_1_o, ext_irq_in_2_o, ext_irq_in_3_o}
        == $past({port_zero_i[7], port_zero_i[6], port_two_i[5]}))
        else $error("irq inputs not following their pins");
    AST_TIMER_ROUTE: assert property ($past(rst_n_i) |->
        {timer_b_ext_clock_o, timer_c_ext_clock_o} == $past(port_two_i[4:3]))
        else $error("timer clocks not following their pins");
    AST_ANALOG_ROUTE: assert property ($past(rst_n_i) |->
        analog_in_o == $past({port_one_i[6], port_two_i[2:0], port_zero_i[6:3]}))
        else $error("analog inputs not following their pins");
    AST_SYNC_ROUTE: assert property ($past(rst_n_i) |->
        {vsync_in_o, hsync_in_o} == $past(port_five_i))
        else $error("sync inputs not following their pins");
    AST_SERIAL_ROUTE: assert property ($past(rst_n_i) |->
        {serbus_in_o, serbus3_in_o, shift_clk_in_o, shift_data_in_o, timer_b_alt_clock_o}
        == $past({port_one_i[4:1], port_three_i, port_two_i[0], port_two_i[2],
                  port_one_i[6]}))
        else $error("serial and timer inputs not following their pins");

    COV_REFUSED: cover property (pslverr);
    COV_WRITE: cover property (psel && penable && pready && pwrite);
    COV_P0_DRIVE: cover property (|port_zero_oe_o);
endmodule

bind port_pins_with_shared_functions port_pins_chk port_pins_chk_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .port_zero_i(port_zero_i), .port_zero_o(port_zero_o),
    .port_zero_oe_o(port_zero_oe_o), .port_one_i(port_one_i),
    .port_one_oe_o(port_one_oe_o), .port_two_i(port_two_i),
    .port_three_oe_o(port_three_oe_o), .port_five_i(port_five_i),
    .ext_irq_in_1_o(ext_irq_in_1_o), .ext_irq_in_2_o(ext_irq_in_2_o),
    .ext_irq_in_3_o(ext_irq_in_3_o), .timer_b_ext_clock_o(timer_b_ext_clock_o),
    .timer_c_ext_clock_o(timer_c_ext_clock_o), .analog_in_o(analog_in_o),
    .hsync_in_o(hsync_in_o), .vsync_in_o(vsync_in_o), .port_three_i(port_three_i),
    .serbus_in_o(serbus_in_o), .serbus3_in_o(serbus3_in_o),
    .shift_clk_in_o(shift_clk_in_o), .shift_data_in_o(shift_data_in_o),
    .timer_b_alt_clock_o(timer_b_alt_clock_o));

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ev;
    logic [7:0]  port_zero_o, port_zero_oe_o, port_two_o, port_two_oe_o;
    logic [6:0]  port_one_o, port_one_oe_o;
    logic [1:0]  port_three_o, port_three_oe_o;
    logic [3:0]  port_five_o;
    logic [24:0] ext_lvl, pin_lvl, oe_all, o_all;
    logic [20:0] pv;
    logic [32:0] exp_q[$];
    logic [7:0]  d, r, b, m, e, l;
    int          num_errors, n_tests, seed;
    int          wd[4] = '{8, 7, 8, 2};
    int          lo[4] = '{0, 8, 15, 23};

    assign oe_all = {port_three_oe_o, port_two_oe_o, port_one_oe_o, port_zero_oe_o};
    assign o_all  = {port_three_o, port_two_o, port_one_o, port_zero_o};

    ////////////////////////////////////////////////////////////////////////////
    pin_board pin_board_inst (.drv_i(o_all), .drv_oe_i(oe_all), .ext_i(ext_lvl),
        .level_o(pin_lvl));
    port_pins_with_shared_functions port_pins_with_shared_functions_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_zero_i(pin_lvl[7:0]),
        .port_zero_o(port_zero_o), .port_zero_oe_o(port_zero_oe_o),
        .port_one_i(pin_lvl[14:8]), .port_one_o(port_one_o),
        .port_one_oe_o(port_one_oe_o), .port_two_i(pin_lvl[22:15]),
        .port_two_o(port_two_o), .port_two_oe_o(port_two_oe_o),
        .port_three_i(pin_lvl[24:23]), .port_three_o(port_three_o),
        .port_three_oe_o(port_three_oe_o), .port_five_i(pv[20:19]),
        .port_five_o(port_five_o), .pulse_out_i(pv[4:0]), .scl1_out_i(pv[5]),
        .scl2_out_i(pv[6]), .sda1_out_i(pv[7]), .sda2_out_i(pv[8]),
        .sda3_out_i(pv[9]), .scl3_out_i(pv[10]), .shift_clk_out_i(pv[11]),
        .shift_clk_oe_i(pv[12]), .shift_data_out_i(pv[13]),
        .clock_control_out_i(pv[14]), .display_out_i(pv[18:15]),
        .serbus_in_o(), .serbus3_in_o(), .shift_clk_in_o(), .shift_data_in_o(),
        .ext_irq_in_1_o(), .ext_irq_in_2_o(), .ext_irq_in_3_o(),
        .timer_b_ext_clock_o(), .timer_b_alt_clock_o(), .timer_c_ext_clock_o(),
        .analog_in_o(), .hsync_in_o(), .vsync_in_o());

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic finish_test();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        n_tests++;
        if (seen !== expv) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    // one bus transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd32);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd32;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // read: note the expected {error, data} then run the transfer
    task automatic rd(input logic [11:0] a, input logic [32:0] expv);
        exp_q.push_back(expv);
        apb(1'b0, a, 32'h0);
    endtask

    // monitor: compare each read answer with the oldest note
    always @(posedge sys_clk_i) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) begin
                check(33'h1ffffffff, 33'h0);
            end else begin
                check({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    // watchdog
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 73;
        rst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        ext_lvl = 25'($random(seed));
        pv = 21'($random(seed));
        // board reset hold shortened to two cycles to keep the run short
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int i = 0; i < 4; i++) rd(12'(8 * i + 4), 33'h0);
        rd(12'h024, 33'h0);
        // per port: latch write as input, then mixed direction
        for (int i = 0; i < 4; i++) begin
            m = 8'hff >> (8 - wd[i]);
            d = 8'($random(seed));
            ev = $random(seed);
            ext_lvl <= ev[24:0];
            b = 8'(ev[24:0] >> lo[i]) & m;
            apb(1'b1, 12'(8 * i), {24'h0, d});
            repeat (2) @(posedge sys_clk_i);
            check(8'(oe_all >> lo[i]) & m, 33'h0);
            rd(12'(8 * i), {25'h0, b});
            ev = $random(seed);
            r = ev[7:0];
            apb(1'b1, 12'(8 * i + 4), ev);
            repeat (2) @(posedge sys_clk_i);
            e = (i == 0) ? (r & ~d & m) : (r & m);
            l = (i == 0) ? (b & ~e) : (((d & r) | (b & ~r)) & m);
            check(8'(oe_all >> lo[i]) & m, e);
            check(8'(pin_lvl >> lo[i]) & m, l);
            rd(12'(8 * i + 4), {25'h0, r & m});
            rd(12'(8 * i), {25'h0, ((d & r) | (l & ~r)) & m});
        end
        // alternate outputs take over, latches keep their values
        d = 8'($random(seed));
        apb(1'b1, 12'h004, 32'hff);
        apb(1'b1, 12'h00c, 32'h7f);
        apb(1'b1, 12'h000, {24'h0, d});
        apb(1'b1, 12'h020, {26'h0, d[5:2], 2'b00});
        apb(1'b1, 12'h024, 32'h19f);
        repeat (2) @(posedge sys_clk_i);
        check(port_zero_oe_o, {~d[7:5], ~pv[4:0]});
        check({port_one_oe_o[0], port_one_o[0]}, {1'b1, pv[14]});
        check(port_five_o, pv[18:15]);
        rd(12'h000, {25'h0, d});
        rd(12'h020, {27'h0, d[5:2], pv[20:19]});
        apb(1'b1, 12'h024, 32'h020);
        repeat (2) @(posedge sys_clk_i);
        check(port_three_oe_o, {~pv[10:9]});
        check(port_one_oe_o[4:1], {~pv[8:5]});
        check(port_five_o, d[5:2]);
        // clocked serial port takes port two bits zero and one, open drain
        apb(1'b1, 12'h024, 32'h040);
        repeat (2) @(posedge sys_clk_i);
        check(port_two_oe_o[1:0], {~pv[13], pv[12] & ~pv[11]});
        // unmapped place: refused, nothing written
        apb(1'b1, 12'h028, 32'hffffffff);
        rd(12'h028, {1'b1, 32'h0});
        // reset in mid-run returns ports zero to three to input
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        rd(12'h004, 33'h0);
        rd(12'h024, 33'h0);
        check(oe_all, 33'h0);
        repeat (3) @(posedge sys_clk_i);
        check(exp_q.size(), 33'h0);
        finish_test();
    end
endmodule
